// ---- inc/vmc_consts.svh ----
// memory geometry, address, mode-field and reset constants of the voice message controller
`ifndef VMC_CONSTS_SVH
`define VMC_CONSTS_SVH

// marker memory geometry
`define VMC_MEM_DEPTH      600
`define VMC_ADDR_W         10
`define VMC_PTR_ZERO       10'h000
`define VMC_PTR_ONE        10'h001
`define VMC_LAST_ADDR      10'h257

// address pin positions that carry mode bits
`define VMC_CUE_BIT        0
`define VMC_DELETE_BIT     1
`define VMC_LOOP_BIT       3
`define VMC_CONSEC_BIT     4
`define VMC_LEVEL_BIT      5
`define VMC_PBUTTON_BIT    6
`define VMC_MSB_LOW_BIT    8
`define VMC_MSB_HIGH_BIT   9

// reset values
`define VMC_MODES_RST      6'h00
`define VMC_SYNC_RST_HI    3'h7
`define VMC_SYNC_RST_LO    3'h0

`endif

// ---- inc/vmc_pkg.sv ----
// types shared by the voice message controller
package vmc_pkg;

  // control sequencer states
  typedef enum logic [2:0] {
    ST_IDLE       = 3'h0,
    ST_PLAY       = 3'h1,
    ST_REC        = 3'h2,
    ST_PAUSE_PLAY = 3'h3,
    ST_PAUSE_REC  = 3'h4,
    ST_CUE        = 3'h5
  } vmc_state_t;

  // mode options sampled from the address pins
  typedef struct packed {
    logic pushbutton;
    logic level_select;
    logic consecutive;
    logic looping;
    logic marker_delete;
    logic cueing;
  } vmc_modes_t;

  // complete state of the sequencer
  typedef struct packed {
    vmc_state_t  state;
    vmc_modes_t  modes;
    logic [9:0]  ptr;
    logic [2:0]  ce_sync;
    logic [2:0]  stop_sync;
    logic        play_last;
    logic        full_flag;
    logic        rd_ok;
    logic        mem_we;
    logic        mem_wd;
    logic [9:0]  mem_wa;
    logic        marker_out;
    logic        full_out_n;
    logic        powered_down;
  } vmc_regs_t;

  // state of the marker memory
  typedef struct packed {
    logic rdata;
  } vmc_mem_regs_t;

endpackage : vmc_pkg

// ---- core/vmc_marker_mem.sv ----
// one-bit-per-row end marker store with registered read data
`include "vmc_consts.svh"
module vmc_marker_mem
  import vmc_pkg::*;
#(
  parameter int DEPTH = `VMC_MEM_DEPTH,
  parameter int AW    = `VMC_ADDR_W
) (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_arst_n,
  // write port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic          i_wdata,
  // read port
  input  wire logic [AW-1:0] i_raddr,
  output logic               o_rdata
);

  logic          mem [DEPTH];
  vmc_mem_regs_t r_reg;
  vmc_mem_regs_t r_next;

  // all rows start without a marker
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = 1'b0;
    end
  end

  // array write
  always_ff @(posedge i_clk) begin
    if (i_we && (int'(i_waddr) < DEPTH)) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // read data is registered, out of range rows read as a marker
  always_comb begin
    r_next = r_reg;
    if (int'(i_raddr) < DEPTH) begin
      r_next.rdata = mem[i_raddr];
    end else begin
      r_next.rdata = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_rdata = r_reg.rdata;

endmodule : vmc_marker_mem

// ---- core/vmc_control.sv ----
// control sequencer of the voice play/record device
`include "vmc_consts.svh"
module vmc_control
  import vmc_pkg::*;
(
  // clock and reset
  input  wire logic       I_MCLK,
  input  wire logic       I_ARST_N,
  // control pins
  input  wire logic       I_CE_N,
  input  wire logic       I_POWERDOWN_STOP_IN,
  input  wire logic       I_PLAY_REC,
  input  wire logic [9:0] I_ADDR,
  // storage timing
  input  wire logic       I_ROW_TICK,
  // status pins
  output logic            O_END_MARKER_RUN_OUT,
  output logic            O_MEMORY_FULL_OUT_N,
  output logic            O_POWERED_DOWN,
  output logic [9:0]      O_ADDR_PTR,
  output logic [2:0]      O_STATE
);

  vmc_regs_t  r_reg;
  vmc_regs_t  r_next;
  logic       mem_rdata;
  logic       ce_s;
  logic       ce_fall;
  logic       ce_rise;
  logic       stop_s;
  logic       stop_rise;
  logic       mode_sel;
  logic       marker;
  logic       tick_ok;
  logic       at_last;
  vmc_modes_t md;

  // next row with wrap at the end of memory
  function automatic logic [9:0] ptr_inc(input logic [9:0] p);
    if (p == `VMC_LAST_ADDR) begin
      ptr_inc = `VMC_PTR_ZERO;
    end else begin
      ptr_inc = p + `VMC_PTR_ONE;
    end
  endfunction : ptr_inc

  // mode bits carried on the address pins
  function automatic vmc_modes_t decode_modes(input logic [9:0] a);
    decode_modes.pushbutton    = a[`VMC_PBUTTON_BIT];
    decode_modes.level_select  = a[`VMC_LEVEL_BIT];
    decode_modes.consecutive   = a[`VMC_CONSEC_BIT];
    decode_modes.looping       = a[`VMC_LOOP_BIT];
    decode_modes.marker_delete = a[`VMC_DELETE_BIT];
    decode_modes.cueing        = a[`VMC_CUE_BIT];
  endfunction : decode_modes

  // marker store, read at the current pointer
  vmc_marker_mem #(
    .DEPTH (`VMC_MEM_DEPTH),
    .AW    (`VMC_ADDR_W)
  ) u_marker_mem (
    .i_clk    (I_MCLK),
    .i_arst_n (I_ARST_N),
    .i_we     (r_reg.mem_we),
    .i_waddr  (r_reg.mem_wa),
    .i_wdata  (r_reg.mem_wd),
    .i_raddr  (r_reg.ptr),
    .o_rdata  (mem_rdata)
  );

  // synchronised levels and their edges, first stage feeds only the second
  assign ce_s      = r_reg.ce_sync[1];
  assign ce_fall   = r_reg.ce_sync[2] & ~ce_s;
  assign ce_rise   = ~r_reg.ce_sync[2] & ce_s;
  assign stop_s    = r_reg.stop_sync[1];
  assign stop_rise = ~r_reg.stop_sync[2] & stop_s;
  assign mode_sel  = I_ADDR[`VMC_MSB_LOW_BIT] & I_ADDR[`VMC_MSB_HIGH_BIT];
  assign marker    = r_reg.rd_ok & mem_rdata;
  assign tick_ok   = I_ROW_TICK & r_reg.rd_ok;
  assign at_last   = (r_reg.ptr == `VMC_LAST_ADDR);
  // every select fall samples modes, a direct address fall clears them
  assign md        = !ce_fall ? r_reg.modes :
                     mode_sel ? decode_modes(I_ADDR) : vmc_modes_t'(`VMC_MODES_RST);

  // sequencer next state
  always_comb begin
    r_next            = r_reg;
    r_next.ce_sync    = {r_reg.ce_sync[1:0], I_CE_N};
    r_next.stop_sync  = {r_reg.stop_sync[1:0], I_POWERDOWN_STOP_IN};
    r_next.play_last  = I_PLAY_REC;
    r_next.mem_we     = 1'b0;
    r_next.mem_wd     = 1'b0;
    r_next.mem_wa     = r_reg.ptr;
    r_next.full_out_n = 1'b1;
    r_next.marker_out = 1'b1;
    r_next.modes      = md;

    // record/play change while idle clears the pointer outside push-button
    if (!md.pushbutton && (I_PLAY_REC != r_reg.play_last) && (r_reg.state == ST_IDLE)) begin
      r_next.ptr = `VMC_PTR_ZERO;
    end

    if (md.pushbutton) begin
      // start/pause button
      if (ce_fall) begin
        case (r_reg.state)
          ST_IDLE: begin
            if (r_reg.full_flag) begin
              r_next.ptr       = `VMC_PTR_ZERO;
              r_next.full_flag = 1'b0;
              r_next.state     = ST_PLAY;
            end else begin
              r_next.state = I_PLAY_REC ? ST_PLAY : ST_REC;
            end
          end
          ST_PLAY: begin
            r_next.state = ST_PAUSE_PLAY;
          end
          ST_REC: begin
            r_next.state  = ST_PAUSE_REC;
            r_next.mem_we = 1'b1;
            r_next.mem_wd = 1'b1;
          end
          ST_PAUSE_PLAY: begin
            r_next.state = I_PLAY_REC ? ST_PLAY : ST_REC;
          end
          ST_PAUSE_REC: begin
            if (I_PLAY_REC) begin
              r_next.ptr   = `VMC_PTR_ZERO;
              r_next.state = ST_PLAY;
            end else if (md.marker_delete) begin
              r_next.mem_we = 1'b1;
              r_next.mem_wd = 1'b0;
              r_next.state  = ST_REC;
            end else begin
              r_next.ptr   = ptr_inc(r_reg.ptr);
              r_next.state = ST_REC;
            end
          end
          default: begin
            r_next.state = ST_IDLE;
          end
        endcase
      end else if (stop_rise && (r_reg.state != ST_IDLE)) begin
        // stop/reset button, recordings keep their end marker
        if ((r_reg.state == ST_REC) || (r_reg.state == ST_PAUSE_REC)) begin
          r_next.mem_we = 1'b1;
          r_next.mem_wd = 1'b1;
        end
        r_next.state = ST_IDLE;
        r_next.ptr   = `VMC_PTR_ZERO;
      end
    end else if (stop_s) begin
      // power-down acts as reset of the cycle and pointer
      if (r_reg.state == ST_REC) begin
        r_next.mem_we = 1'b1;
        r_next.mem_wd = 1'b1;
      end
      r_next.state = ST_IDLE;
      r_next.ptr   = `VMC_PTR_ZERO;
    end else if (ce_fall) begin
      // microcontroller start, with direct address or mode set
      if (mode_sel || (I_ADDR <= `VMC_LAST_ADDR)) begin
        if (!mode_sel) begin
          r_next.ptr = I_ADDR;
        end else if (r_reg.full_flag || (md.level_select && !md.consecutive)) begin
          r_next.ptr = `VMC_PTR_ZERO;
        end
        r_next.full_flag = 1'b0;
        if (!I_PLAY_REC) begin
          r_next.state = ST_REC;
        end else if (mode_sel && md.cueing) begin
          r_next.state = ST_CUE;
        end else if (r_reg.state == ST_IDLE) begin
          r_next.state = ST_PLAY;
        end
      end
    end else if (ce_rise) begin
      // rising select ends level-held operations
      if (r_reg.state == ST_REC) begin
        r_next.state  = ST_IDLE;
        r_next.mem_we = 1'b1;
        r_next.mem_wd = 1'b1;
      end else if ((r_reg.state == ST_PLAY) && md.level_select) begin
        r_next.state = ST_IDLE;
      end
    end

    // row progress while nothing above moved the sequencer
    if (r_next.state == r_reg.state && r_next.ptr == r_reg.ptr && !r_next.mem_we) begin
      case (r_reg.state)
        ST_PLAY: begin
          if (tick_ok && marker) begin
            if (!md.pushbutton) begin
              r_next.marker_out = 1'b0;
            end
            if (md.looping) begin
              r_next.ptr = `VMC_PTR_ZERO;
            end else if (md.pushbutton) begin
              r_next.state = ST_PAUSE_PLAY;
              r_next.ptr   = ptr_inc(r_reg.ptr);
            end else begin
              r_next.state = ST_IDLE;
              r_next.ptr   = md.consecutive ? ptr_inc(r_reg.ptr) : `VMC_PTR_ZERO;
            end
          end else if (tick_ok && at_last) begin
            if (md.looping) begin
              r_next.ptr = `VMC_PTR_ZERO;
            end else begin
              r_next.full_out_n = 1'b0;
              r_next.full_flag  = 1'b1;
              r_next.state      = ST_IDLE;
            end
          end else if (tick_ok) begin
            r_next.ptr = ptr_inc(r_reg.ptr);
          end
        end
        ST_REC: begin
          if (tick_ok) begin
            // writing a row clears any stale marker there, the last row is written with a marker
            r_next.mem_we = 1'b1;
            r_next.mem_wd = at_last;
            if (at_last) begin
              r_next.full_out_n = 1'b0;
              r_next.full_flag  = 1'b1;
              r_next.state      = ST_IDLE;
            end else begin
              r_next.ptr = ptr_inc(r_reg.ptr);
            end
          end
        end
        ST_CUE: begin
          // skip rows until a marker, then land after it
          if (marker) begin
            r_next.ptr   = ptr_inc(r_reg.ptr);
            r_next.state = ST_IDLE;
          end else if (r_reg.rd_ok && at_last) begin
            r_next.full_out_n = 1'b0;
            r_next.full_flag  = 1'b1;
            r_next.state      = ST_IDLE;
          end else if (r_reg.rd_ok) begin
            r_next.ptr = ptr_inc(r_reg.ptr);
          end
        end
        default: begin
        end
      endcase
    end

    // run indicator in push-button operation
    if (md.pushbutton) begin
      r_next.marker_out = (r_next.state == ST_PLAY) || (r_next.state == ST_REC);
    end
    // idle push-button part sleeps once select is released
    r_next.powered_down = stop_s ||
      (md.pushbutton && (r_next.state == ST_IDLE) && ce_s);
    // read data is trusted only after a settled pointer and no write in flight
    r_next.rd_ok = (r_next.ptr == r_reg.ptr) && !r_next.mem_we && !r_reg.mem_we;
  end

  // state register
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      r_reg              <= '0;
      r_reg.state        <= ST_IDLE;
      r_reg.modes        <= `VMC_MODES_RST;
      r_reg.ptr          <= `VMC_PTR_ZERO;
      r_reg.ce_sync      <= `VMC_SYNC_RST_HI;
      r_reg.stop_sync    <= `VMC_SYNC_RST_LO;
      r_reg.marker_out   <= 1'b1;
      r_reg.full_out_n   <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from flip-flops
  assign O_END_MARKER_RUN_OUT = r_reg.marker_out;
  assign O_MEMORY_FULL_OUT_N  = r_reg.full_out_n;
  assign O_POWERED_DOWN       = r_reg.powered_down;
  assign O_ADDR_PTR           = r_reg.ptr;
  assign O_STATE              = r_reg.state;

  // checks
  chk_full_pulse_single: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    !O_MEMORY_FULL_OUT_N |=> O_MEMORY_FULL_OUT_N)
    else $error("memory full pulse longer than one cycle");

  chk_run_indicator: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    r_reg.modes.pushbutton |->
      (O_END_MARKER_RUN_OUT == ((r_reg.state == ST_PLAY) || (r_reg.state == ST_REC))))
    else $error("run indicator does not follow activity");

  chk_stop_zeroes_ptr: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    (md.pushbutton && stop_rise && !ce_fall && (r_reg.state != ST_IDLE)) |=>
      (O_ADDR_PTR == `VMC_PTR_ZERO) && (r_reg.state == ST_IDLE))
    else $error("stop pulse did not end cycle at row zero");

  chk_level_stop_now: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    (!md.pushbutton && md.level_select && !stop_s && ce_rise && (r_reg.state == ST_PLAY))
      |=> (r_reg.state == ST_IDLE))
    else $error("level mode playback kept running after select rose");

  chk_pause_keeps_ptr: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    (md.pushbutton && ce_fall && (r_reg.state == ST_PLAY)) |=>
      (r_reg.state == ST_PAUSE_PLAY) && $stable(r_reg.ptr))
    else $error("pause lost the pointer");

  chk_pause_rec_marker: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    (md.pushbutton && ce_fall && (r_reg.state == ST_REC)) |=>
      r_reg.mem_we && r_reg.mem_wd && (r_reg.mem_wa == $past(r_reg.ptr)) && !O_END_MARKER_RUN_OUT)
    else $error("paused recording did not store a marker");

  chk_ptr_in_range: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    O_ADDR_PTR <= `VMC_LAST_ADDR)
    else $error("pointer beyond last row");

  chk_consec_advance: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    (!md.pushbutton && !stop_s && !ce_fall && !ce_rise && md.consecutive && !md.looping &&
     (r_reg.state == ST_PLAY) && tick_ok && marker)
      |=> (r_reg.ptr == ptr_inc($past(r_reg.ptr))) ##1 (r_reg.state == ST_IDLE))
    else $error("consecutive mode lost the pointer at a marker");

  chk_resume_rec: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    (md.pushbutton && ce_fall && !I_PLAY_REC && !md.marker_delete &&
     (r_reg.state == ST_PAUSE_REC)) |=> (r_reg.ptr == ptr_inc($past(r_reg.ptr))) && O_END_MARKER_RUN_OUT)
    else $error("resumed recording not placed after marker");

endmodule : vmc_control

// ---- testbench/vmc_button_model.sv ----
// push-button and host model driving the sequencer control pins
module vmc_button_model
  import vmc_pkg::*;
(
  // clock
  input  wire logic  i_clk,
  // control pins toward the device
  output logic       o_ce_n,
  output logic       o_stop,
  output logic       o_play_rec,
  output logic [9:0] o_addr,
  output logic       o_row_tick
);
  timeunit 1ns;
  timeprecision 1ps;

  // released buttons: select pulled high, stop pulled low
  initial begin
    o_ce_n     = 1'b1;
    o_stop     = 1'b0;
    o_play_rec = 1'b1;
    o_addr     = 10'h000;
    o_row_tick = 1'b0;
  end

  // address or mode levels, held steady across the next select fall
  task automatic setup(input logic [9:0] addr, input logic pr);
    @(negedge i_clk);
    o_addr     = addr;
    o_play_rec = pr;
  endtask : setup

  // select level held long enough to pass the synchroniser
  task automatic ce_level(input logic lvl);
    @(negedge i_clk);
    o_ce_n = lvl;
    repeat ($urandom_range(8, 4)) @(negedge i_clk);
  endtask : ce_level

  // one start/pause press
  task automatic press_ce();
    ce_level(1'b0);
    ce_level(1'b1);
  endtask : press_ce

  // one stop/reset press
  task automatic press_stop();
    @(negedge i_clk);
    o_stop = 1'b1;
    repeat (5) @(negedge i_clk);
    o_stop = 1'b0;
    repeat (6) @(negedge i_clk);
  endtask : press_stop

  // row ticks, one cycle wide, a random five to seven cycles apart
  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge i_clk);
      o_row_tick = 1'b1;
      @(negedge i_clk);
      o_row_tick = 1'b0;
      repeat ($urandom_range(5, 3)) @(negedge i_clk);
    end
  endtask : ticks
endmodule : vmc_button_model

// ---- testbench/vmc_control_tb.sv ----
// self-checking bench of the voice message control sequencer
module vmc_control_tb
  import vmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       mclk = 1'b0;
  logic       arst_n = 1'b0;
  logic       ce_n;
  logic       stop;
  logic       play_rec;
  logic [9:0] addr;
  logic       row_tick;
  logic       run_out;
  logic       full_n;
  logic       pdown;
  logic [9:0] ptr;
  logic [2:0] state;
  int         full_cnt = 0;
  int         mark_cnt = 0;
  int         errors = 0;
  int         tests_run = 0;

  // 100 MHz clock
  always #5 mclk = ~mclk;

  vmc_control dut (
    .I_MCLK              (mclk),
    .I_ARST_N            (arst_n),
    .I_CE_N              (ce_n),
    .I_POWERDOWN_STOP_IN (stop),
    .I_PLAY_REC          (play_rec),
    .I_ADDR              (addr),
    .I_ROW_TICK          (row_tick),
    .O_END_MARKER_RUN_OUT(run_out),
    .O_MEMORY_FULL_OUT_N (full_n),
    .O_POWERED_DOWN      (pdown),
    .O_ADDR_PTR          (ptr),
    .O_STATE             (state)
  );

  vmc_button_model btn (
    .i_clk     (mclk),
    .o_ce_n    (ce_n),
    .o_stop    (stop),
    .o_play_rec(play_rec),
    .o_addr    (addr),
    .o_row_tick(row_tick)
  );

  // count the cycles in which the status pins stand low
  always @(posedge mclk) begin
    if (full_n === 1'b0) full_cnt <= full_cnt + 1;
    if (run_out === 1'b0) mark_cnt <= mark_cnt + 1;
  end

  // row after the first end marker past row k, from the markers the scenarios leave
  function automatic logic [15:0] cue_dest(input int n, input int m, input int k);
    if (n > k) return 16'(n + 1);
    if (n + 1 > k) return 16'(n + 2);
    if (n + 1 + m > k) return 16'(n + m + 2);
    return 16'h0241;
  endfunction : cue_dest

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // expected run indicator of a push-button state
  function automatic logic [15:0] run_of(input vmc_state_t s);
    return 16'((s == ST_PLAY) || (s == ST_REC));
  endfunction : run_of

  task automatic st(input vmc_state_t s, input logic [9:0] p, input logic pb);
    check(16'(state), 16'(s));
    check(16'(ptr), 16'(p));
    if (pb) check(16'(run_out), run_of(s));
  endtask : st

  // start or resume playback, tick until it stops by itself
  task automatic play_on();
    int j;
    j = 0;
    btn.press_ce();
    while (state === ST_PLAY && j < 20) begin
      btn.ticks(1);
      j++;
    end
  endtask : play_on

  task automatic end_of_test();
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  // watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    end_of_test();
  end

  initial begin
    logic [9:0] a;
    int         n;
    int         m;
    int         k;
    int         f0;
    int         m0;
    int         j;
    void'($urandom(87));
    n = $urandom_range(6, 3);
    m = $urandom_range(6, 1);
    k = $urandom_range(6, 3);
    repeat (12) @(posedge mclk);
    st(ST_IDLE, 10'h000, 1'b0);
    check({13'h0, run_out, full_n, pdown}, 16'h0006);
    @(negedge mclk);
    arst_n = 1'b1;
    // direct address with modes off: record follows the select level
    btn.setup(10'h240, 1'b0);
    btn.ce_level(1'b0);
    st(ST_REC, 10'h240, 1'b0);
    btn.ce_level(1'b1);
    check(16'(state), 16'(ST_IDLE));
    btn.press_stop();
    st(ST_IDLE, 10'h000, 1'b0);
    // push-button recording: start, pause, resume, stop
    btn.setup(10'h340, 1'b0);
    btn.press_ce();
    st(ST_REC, 10'h000, 1'b1);
    btn.ticks(n);
    btn.press_ce();
    st(ST_PAUSE_REC, 10'(n), 1'b1);
    btn.press_ce();
    st(ST_REC, 10'(n + 1), 1'b1);
    btn.ticks(m);
    btn.press_stop();
    st(ST_IDLE, 10'h000, 1'b1);
    check(16'(pdown), 16'h0001);
    // push-button playback halts at the pause marker
    btn.setup(10'h340, 1'b1);
    play_on();
    st(ST_PAUSE_PLAY, 10'(n + 1), 1'b1);
    btn.press_ce();
    st(ST_PLAY, 10'(n + 1), 1'b1);
    btn.press_ce();
    st(ST_PAUSE_PLAY, 10'(n + 1), 1'b1);
    btn.setup(10'h340, 1'b0);
    btn.press_ce();
    st(ST_REC, 10'(n + 1), 1'b1);
    btn.press_stop();
    btn.setup(10'h340, 1'b1);
    play_on();
    play_on();
    st(ST_PAUSE_PLAY, 10'(n + 2), 1'b1);
    btn.press_stop();
    // delete mode resume, then play after paused recording
    btn.setup(10'h342, 1'b0);
    btn.press_ce();
    btn.ticks(k);
    btn.press_ce();
    btn.press_ce();
    st(ST_REC, 10'(k), 1'b1);
    btn.press_ce();
    btn.setup(10'h342, 1'b1);
    btn.press_ce();
    st(ST_PLAY, 10'h000, 1'b1);
    btn.press_stop();
    // direct playback: edge start, further falls ignored, stop zeroes
    repeat (3) begin
      a = 10'($urandom_range(599, 0));
      btn.setup(a, 1'b1);
      btn.press_ce();
      st(ST_PLAY, a, 1'b0);
      btn.press_ce();
      st(ST_PLAY, a, 1'b0);
      btn.press_stop();
      st(ST_IDLE, 10'h000, 1'b0);
    end
    a = 10'($urandom_range(767, 600));
    btn.setup(a, 1'b1);
    btn.press_ce();
    check(16'(state), 16'(ST_IDLE));
    // end of memory gives the full pulse, not the marker pulse
    btn.setup(10'h255, 1'b1);
    btn.press_ce();
    f0 = full_cnt;
    m0 = mark_cnt;
    btn.ticks(2);
    check(16'(full_cnt - f0), 16'h0000);
    btn.ticks(1);
    check(16'(full_cnt - f0), 16'h0001);
    check(16'(mark_cnt - m0), 16'h0000);
    btn.press_stop();
    // level mode: play while low, stop on rise, restart from zero
    btn.setup(10'h320, 1'b1);
    btn.ce_level(1'b0);
    btn.ticks(2);
    st(ST_PLAY, 10'h002, 1'b0);
    btn.ce_level(1'b1);
    check(16'(state), 16'(ST_IDLE));
    btn.ce_level(1'b0);
    st(ST_PLAY, 10'h000, 1'b0);
    btn.ce_level(1'b1);
    // consecutive mode: playback stops past the marker instead of at zero
    btn.setup(10'h310, 1'b1);
    m0 = mark_cnt;
    play_on();
    st(ST_IDLE, 10'(k + 1), 1'b0);
    check(16'(mark_cnt - m0), 16'h0001);
    // cueing: skip to the row after the next marker
    btn.setup(10'h301, 1'b1);
    btn.press_ce();
    j = 0;
    while (state === ST_CUE && j < 1500) begin
      @(negedge mclk);
      j++;
    end
    check(16'(state), 16'(ST_IDLE));
    check(16'(ptr), cue_dest(n, m, k));
    end_of_test();
  end
endmodule : vmc_control_tb
